// ===== design/omc_defs.vh
// constants for the operating mode controller
// assumes one 100 MHz clock and a synchronous active-high reset
`ifndef OMC_DEFS_VH
`define OMC_DEFS_VH
`define OMC_MODE_RESET   2'h0
`define OMC_MODE_ACTIVE  2'h1
`define OMC_MODE_STANDBY 2'h2
`define OMC_MODE_SLEEP   2'h3
`define OMC_BIT_SCLK     0
`define OMC_BIT_SDATA    1
`define OMC_BIT_EVENT    3
`define OMC_BIT_BUZZ     0
`define OMC_WAKE_CYCLES  16'h0010
`define OMC_STB_CYCLES   4'h1
`endif

// ===== design/omc_pin_mux.v
// pin role multiplexer: buzzer, serial write buffer and event input
// assumes the port latch values come from elsewhere in the core
`include "omc_defs.vh"
`default_nettype none
module omc_pin_mux (
	// package selection
	input  wire       pkg28,
	// port latches and special functions
	input  wire [3:0] portBLatch,
	input  wire [3:0] portDLatch,
	input  wire [3:0] portELatch,
	input  wire       buzzEn,
	input  wire       buzzWave,
	input  wire       swbEn,
	input  wire       swbClk,
	input  wire       swbData,
	input  wire [3:0] portAIn,
	// muxed results
	output reg  [3:0] portBOut,
	output reg  [3:0] portDOut,
	output reg  [3:0] portEOut,
	output wire       eventClk
);
	assign eventClk = portAIn[`OMC_BIT_EVENT];
	always @* begin
		portBOut = portBLatch;
		portDOut = portDLatch;
		portEOut = portELatch;
		if (buzzEn && !pkg28)
			portBOut[`OMC_BIT_BUZZ] = buzzWave;
		if (buzzEn && pkg28)
			portEOut[`OMC_BIT_BUZZ] = buzzWave;
		if (swbEn) begin
			portDOut[`OMC_BIT_SCLK] = swbClk;
			portDOut[`OMC_BIT_SDATA] = swbData;
		end
	end
endmodule
`default_nettype wire

// ===== design/omc_mode_ctrl.v
// operating mode controller: reset, active, standby and sleep
// assumes inputs are synchronous to ref_clk; the wake delay models the
// oscillator cold start and runs on every entry to reset mode, not only after sleep
`include "omc_defs.vh"
`default_nettype none
module omc_mode_ctrl #(
	parameter WAKE_CYCLES = `OMC_WAKE_CYCLES
) (
	// clock and reset
	input  wire       ref_clk,
	input  wire       reset,
	// reset sources
	input  wire       resetPin,
	input  wire [3:0] portAIn,
	input  wire [3:0] resetCombo,
	// cpu events
	input  wire       haltExec,
	input  wire       intReq,
	input  wire       sleepWrite,
	input  wire       sleepGuardWrite,
	input  wire       sleepGuardData,
	input  wire       portWrite,
	// pin functions
	input  wire       pkg28,
	input  wire [3:0] portBLatch,
	input  wire [3:0] portDLatch,
	input  wire [3:0] portELatch,
	input  wire       buzzEn,
	input  wire       buzzWave,
	input  wire       swbEn,
	input  wire       swbClk,
	input  wire       swbData,
	// status
	output reg  [1:0] mode_r,
	output reg        cpuClkEn_r,
	output reg        periphClkEn_r,
	output reg        strobeResetStatusOut_r,
	output reg        sleepGuard_r,
	output reg        sleepFlag_r,
	// ports and event clock
	output reg  [3:0] portBOut_r,
	output reg  [3:0] portDOut_r,
	output reg  [3:0] portEOut_r,
	output reg        eventClk_r
);
	reg  [1:0]  mode_nxt;
	reg  [15:0] wakeCnt_r;
	wire [3:0]  muxB;
	wire [3:0]  muxD;
	wire [3:0]  muxE;
	wire        muxEvt;
	wire        comboHit;

	// an all-zero combination means the option is absent
	function comboMatch;
		input [3:0] pins;
		input [3:0] sel;
		begin
			comboMatch = (sel != 4'h0) && ((pins & sel) == sel);
		end
	endfunction

	assign comboHit = comboMatch(portAIn, resetCombo);

	omc_pin_mux uMux (
		.pkg28      (pkg28),
		.portBLatch (portBLatch),
		.portDLatch (portDLatch),
		.portELatch (portELatch),
		.buzzEn     (buzzEn),
		.buzzWave   (buzzWave),
		.swbEn      (swbEn),
		.swbClk     (swbClk),
		.swbData    (swbData),
		.portAIn    (portAIn),
		.portBOut   (muxB),
		.portDOut   (muxD),
		.portEOut   (muxE),
		.eventClk   (muxEvt)
	);

	always @* begin
		mode_nxt = mode_r;
		case (mode_r)
		`OMC_MODE_RESET:
			if (wakeCnt_r == 16'h0000)
				mode_nxt = `OMC_MODE_ACTIVE;
		`OMC_MODE_ACTIVE:
			if (resetPin || comboHit)
				mode_nxt = `OMC_MODE_RESET;
			else if (sleepWrite && sleepGuard_r)
				mode_nxt = `OMC_MODE_SLEEP;
			else if (haltExec)
				mode_nxt = `OMC_MODE_STANDBY;
		`OMC_MODE_STANDBY:
			if (resetPin || comboHit)
				mode_nxt = `OMC_MODE_RESET;
			else if (intReq)
				mode_nxt = `OMC_MODE_ACTIVE;
		`OMC_MODE_SLEEP:
			// interrupts cannot wake sleep
			if (resetPin || comboHit)
				mode_nxt = `OMC_MODE_RESET;
		default:
			mode_nxt = `OMC_MODE_RESET;
		endcase
	end

	always @(posedge ref_clk) begin
		if (reset) begin
			mode_r <= `OMC_MODE_RESET;
			wakeCnt_r <= `OMC_WAKE_CYCLES;
			cpuClkEn_r <= 1'b0;
			periphClkEn_r <= 1'b0;
			strobeResetStatusOut_r <= 1'b1;
			sleepGuard_r <= 1'b0;
			sleepFlag_r <= 1'b0;
			portBOut_r <= 4'h0;
			portDOut_r <= 4'h0;
			portEOut_r <= 4'h0;
			eventClk_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			if (mode_nxt == `OMC_MODE_RESET && mode_r != `OMC_MODE_RESET)
				wakeCnt_r <= WAKE_CYCLES[15:0];
			else if (mode_r == `OMC_MODE_RESET && wakeCnt_r != 16'h0000)
				wakeCnt_r <= wakeCnt_r - 16'h0001;
			// instruction clock only in active mode
			cpuClkEn_r <= (mode_nxt == `OMC_MODE_ACTIVE);
			// peripherals and timers stay clocked except in sleep
			periphClkEn_r <= (mode_nxt != `OMC_MODE_SLEEP);
			strobeResetStatusOut_r <= (mode_nxt == `OMC_MODE_RESET) ||
				(portWrite && mode_r == `OMC_MODE_ACTIVE);
			if (sleepGuardWrite && mode_r == `OMC_MODE_ACTIVE)
				sleepGuard_r <= sleepGuardData;
			if (mode_r == `OMC_MODE_SLEEP && mode_nxt == `OMC_MODE_RESET)
				sleepFlag_r <= 1'b0;
			else if (mode_nxt == `OMC_MODE_SLEEP)
				sleepFlag_r <= 1'b1;
			// pins hold outside active so latches are never disturbed
			if (mode_r == `OMC_MODE_ACTIVE) begin
				portBOut_r <= muxB;
				portDOut_r <= muxD;
				portEOut_r <= muxE;
			end
			eventClk_r <= muxEvt;
		end
	end
endmodule
`default_nettype wire

// ===== verification/omc_assertions.sv
// omc checker: mode and pin relations over time
// bound to omc_mode_ctrl; sees its ports only
`default_nettype none
module omc_checker (
	input wire logic ref_clk, reset, resetPin, haltExec, intReq,
	input wire logic sleepWrite, portWrite, pkg28, buzzEn, buzzWave,
	input wire logic swbEn, swbClk, cpuClkEn_r, periphClkEn_r,
	input wire logic strobeResetStatusOut_r, sleepGuard_r, sleepFlag_r,
	input wire logic [1:0] mode_r,
	input wire logic [3:0] resetCombo, portBOut_r, portDOut_r, portAIn
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	AST_HALT: assert property (mode_r == 1 && haltExec && !resetPin &&
		!sleepWrite && resetCombo == 0 |=> mode_r == 2) else $error("halt");
	AST_GATE: assert property (mode_r == 2 |->
		!cpuClkEn_r && periphClkEn_r) else $error("gate");
	AST_WAKE: assert property (mode_r == 2 && intReq && !resetPin &&
		resetCombo == 0 |=> mode_r == 1 && cpuClkEn_r) else $error("wake");
	AST_HOLD: assert property (mode_r == 2 && !resetPin |=>
		$stable(portBOut_r) && $stable(portDOut_r)) else $error("hold");
	AST_RST: assert property (mode_r == 0 |->
		strobeResetStatusOut_r) else $error("strobe in reset");
	AST_STB: assert property (mode_r == 1 && portWrite |=>
		strobeResetStatusOut_r) else $error("strobe on write");
	AST_GRD: assert property (mode_r == 1 && sleepWrite &&
		!sleepGuard_r |=> mode_r != 3) else $error("guard");
	// the selected port A combination is a legal sleep exit as well
	AST_SLP: assert property (mode_r == 3 && !resetPin &&
		(resetCombo == 0 || (portAIn & resetCombo) != resetCombo) |=>
		mode_r == 3) else $error("sleep exit");
	AST_SWK: assert property (mode_r == 3 && resetPin |=> mode_r == 0 &&
		sleepGuard_r && !sleepFlag_r) else $error("sleep wake");
	AST_BUZ: assert property (mode_r == 1 && buzzEn && !pkg28 |=>
		portBOut_r[0] == $past(buzzWave)) else $error("buzzer");
	AST_SWB: assert property (mode_r == 1 && swbEn |=>
		portDOut_r[0] == $past(swbClk)) else $error("serial clock");
	cover property (mode_r == 2 ##1 mode_r == 1);
	cover property (mode_r == 3 ##1 mode_r == 0);
	cover property (mode_r == 1 && portWrite);
endmodule
bind omc_mode_ctrl omc_checker u_chk (.*);
`default_nettype wire

// ===== verification/omc_tb.sv
// omc bench: table of pin cases, then mode walks
// drives every input on the falling edge of ref_clk
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, reset = 1, resetPin = 0, haltExec = 0, intReq = 0;
	logic sleepWrite = 0, sleepGuardWrite = 0, sleepGuardData = 0;
	logic portWrite = 0, pkg28 = 0, buzzEn = 0, buzzWave = 0;
	logic swbEn = 0, swbClk = 0, swbData = 0;
	logic [3:0] portAIn = 0, resetCombo = 0, portBLatch = 4'hA;
	logic [3:0] portDLatch = 4'hC, portELatch = 4'h5;
	wire [1:0] mode_r;
	wire cpuClkEn_r, periphClkEn_r, strobeResetStatusOut_r;
	wire sleepGuard_r, sleepFlag_r, eventClk_r;
	wire [3:0] portBOut_r, portDOut_r, portEOut_r;
	int n_mismatch = 0, cmp_count = 0;
	// inputs {pkg28,buzzEn,buzzWave,swbEn,swbClk,swbData}, out {B0,E0,D1,D0}
	logic [9:0] rows [4] = '{10'h1ED, 10'h352, 10'h0B4, 10'h277};
	omc_mode_ctrl dut_u (.*);
	initial forever #5 ref_clk = ~ref_clk;
	task automatic chk(input logic [3:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		tick(1);
		s = 0;
	endtask
	// bounded wait: wake delay follows every reset
	task automatic toact;
		for (int i = 0; i < 40 && mode_r !== 2'h1; i++) tick(1);
	endtask
	task end_of_test;
		if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#20000;
		n_mismatch++;
		end_of_test;
	end
	initial begin
		tick(12);
		chk({mode_r, strobeResetStatusOut_r, cpuClkEn_r}, 4'h2);
		reset = 0;
		toact;
		chk(mode_r, 4'h1);
		foreach (rows[i]) begin
			{pkg28, buzzEn, buzzWave, swbEn, swbClk, swbData} = rows[i][9:4];
			portAIn = 4'(i << 3);
			tick(1);
			chk({portBOut_r[0], portEOut_r[0], portDOut_r[1:0]}, rows[i][3:0]);
			chk(eventClk_r, 4'(i % 2));
		end
		{pkg28, buzzEn, swbEn} = 3'h0;
		pulse(haltExec);
		chk({mode_r, cpuClkEn_r, periphClkEn_r}, 4'h9);
		portBLatch = 4'h3;
		tick(2);
		chk(portBOut_r, 4'hA);
		pulse(intReq);
		chk({mode_r, cpuClkEn_r}, 4'h3);
		tick(1);
		chk(portBOut_r, 4'h3);
		pulse(haltExec);
		pulse(resetPin);
		chk(mode_r, 4'h0);
		toact;
		pulse(portWrite);
		chk(strobeResetStatusOut_r, 4'h1);
		pulse(sleepWrite);
		chk(mode_r, 4'h1);
		sleepGuardData = 1;
		pulse(sleepGuardWrite);
		pulse(sleepWrite);
		chk({mode_r, sleepFlag_r, periphClkEn_r}, 4'hE);
		resetCombo = 4'h3;
		// half a combination and an interrupt must both leave sleep alone
		portAIn = 4'h1;
		pulse(intReq);
		tick(1);
		chk(mode_r, 4'h3);
		portAIn = 4'h0;
		pulse(resetPin);
		chk({mode_r, sleepFlag_r, sleepGuard_r}, 4'h1);
		toact;
		portAIn = 4'h3;
		tick(2);
		chk(mode_r, 4'h0);
		portAIn = 4'h0;
		toact;
		pulse(sleepWrite);
		chk(mode_r, 4'h3);
		portAIn = 4'h3;
		tick(1);
		chk({mode_r, sleepFlag_r, sleepGuard_r}, 4'h1);
		end_of_test;
	end
endmodule
`default_nettype wire
